// ==== hw/ucpc_defines.vh ====
`ifndef UCPC_DEFINES_VH
`define UCPC_DEFINES_VH

// Mode select encodings {bit2, bit1, bit0}
`define UCPC_MODE_CDP 3'h7
`define UCPC_MODE_SDP_A 3'h6
`define UCPC_MODE_SDP_B 3'h2
`define UCPC_MODE_DCP_AUTO 3'h1
`define UCPC_MODE_DCP_STD 3'h4
`define UCPC_MODE_DCP_DIV 3'h5

// Profile codes driven to the emulator
`define UCPC_PROF_OFF 3'h0
`define UCPC_PROF_SDP 3'h1
`define UCPC_PROF_CDP 3'h2
`define UCPC_PROF_DCP_AUTO 3'h3
`define UCPC_PROF_DCP_STD 3'h4
`define UCPC_PROF_DCP_DIV 3'h5

// Timing: seconds as printed, clock in Hz
`define UCPC_CLK_HZ 48'h00000BEBC200
`define UCPC_ATTACH_S 48'h000000000019
`define UCPC_SAFETY_S 48'h000000002A30
`define UCPC_DEGLITCH_CYC 16'h0100

// Wishbone register byte offsets
`define UCPC_ADDR_CTRL 4'h0
`define UCPC_ADDR_STATUS 4'h4
`define UCPC_ADDR_IRQ_STAT 4'h8
`define UCPC_ADDR_IRQ_MASK 4'hC

// Control register fields
`define UCPC_CTRL_BATT 0
`define UCPC_CTRL_SLEEP 1

// Interrupt status fields
`define UCPC_IRQ_ATTACH 0
`define UCPC_IRQ_TIMEOUT 1
`define UCPC_IRQ_FAULT 2
`define UCPC_IRQ_CHG_ON 3
`define UCPC_IRQ_W 4

`endif

// ==== hw/ucpc_deglitch.v ====
`timescale 1ns/1ps
`include "ucpc_defines.vh"

module ucpc_deglitch #(
  parameter W = 16,
  parameter [15:0] HOLD = `UCPC_DEGLITCH_CYC
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Raw level, already synchronised
  input wire raw_in,
  // Filtered level
  output reg level_out
);
  reg [W-1:0] cnt;

  // A change only passes once it has held steady for HOLD+1 cycles
  always @(posedge clk_in) begin
    if (srst_in) begin
      cnt <= {W{1'b0}};
      level_out <= 1'b0;
    end else if (raw_in == level_out) begin
      cnt <= {W{1'b0}};
    end else if (cnt == HOLD[W-1:0]) begin
      cnt <= {W{1'b0}};
      level_out <= raw_in;
    end else begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== hw/ucpc_top.v ====
// How it works
// [R1] CDP/DCP: indicate when current above 20 mA
// [R2] CDP: indicate only if handshake came first
// [R3] Release indication on low current or timeout
// [R4] Sleep on battery: three-hour timer stops charging
// [R5] Safety timer starts only after attach event
// [R6] Attach enable low cancels safety timer
// [R7] Attach detector on: attach enable high, enable low
// [R8] Attach event asserts indication for pulse time
// [R9] Enable low: switches and emulator off
// [R10] Enable gates all but attach detection; here fault detection and its indication stay active with enable low
// [R11] Deglitched fault on overcurrent, thermal, reverse
// [R12] Indication is active-low open drain
// [R13] Three mode inputs select emulation profile
// [R14] 111 CDP; 110 and 010 SDP
// [R15] 001 DCP auto, 100 DCP standard, 101 divider
// [R16] Timers count cycles of internal clock
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ucpc_defines.vh"

module ucpc_top #(
  parameter [47:0] ATTACH_CYC = `UCPC_ATTACH_S * `UCPC_CLK_HZ,
  parameter [47:0] SAFETY_CYC = `UCPC_SAFETY_S * `UCPC_CLK_HZ
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Host control pins
  input wire enable_in,
  input wire attach_enable_in,
  input wire mode_select_bit0_in,
  input wire mode_select_bit1_in,
  input wire mode_select_bit2_in,
  // Analog sense inputs
  input wire current_above_in,
  input wire cdp_handshake_done_in,
  input wire attach_sense_in,
  input wire overcurrent_in,
  input wire thermal_in,
  input wire reverse_in,
  // Switch and emulator controls
  output reg power_switch_on_out,
  output reg data_switch_on_out,
  output reg [2:0] profile_out,
  output reg attach_detector_on_out,
  // Open-drain indications
  output wire charge_attach_out,
  output wire charge_attach_oe_out,
  output wire fault_out,
  output wire fault_oe_out,
  // Wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [3:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Interrupt
  output wire irq_out
);
  // Two-flop synchronisers for all eleven control and sense pins
  localparam NSYNC = 11;
  wire [NSYNC-1:0] raw = {enable_in, attach_enable_in, mode_select_bit2_in,
    mode_select_bit1_in, mode_select_bit0_in, current_above_in,
    cdp_handshake_done_in, attach_sense_in, overcurrent_in, thermal_in, reverse_in};
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  always @(posedge clk_in) begin
    if (srst_in) begin
      sync_a <= {NSYNC{1'b0}};
      sync_b <= {NSYNC{1'b0}};
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end
  wire en_s = sync_b[10];
  wire aen_s = sync_b[9];
  wire [2:0] mode_s = sync_b[8:6];
  wire cur_s = sync_b[5];
  wire hs_s = sync_b[4];
  wire att_s = sync_b[3];
  wire fault_raw = sync_b[2] | sync_b[1] | sync_b[0];

  // Control register: battery supply and sleep state
  reg [1:0] ctrl;
  reg [`UCPC_IRQ_W-1:0] irq_stat;
  reg [`UCPC_IRQ_W-1:0] irq_mask;
  wire on_battery = ctrl[`UCPC_CTRL_BATT];
  wire deep_sleep = ctrl[`UCPC_CTRL_SLEEP];

  // Mode decode
  reg [2:0] next_profile;
  always @* begin
    case (mode_s)
      `UCPC_MODE_CDP: next_profile = `UCPC_PROF_CDP; // R14
      `UCPC_MODE_SDP_A: next_profile = `UCPC_PROF_SDP; // R14
      `UCPC_MODE_SDP_B: next_profile = `UCPC_PROF_SDP;
      `UCPC_MODE_DCP_AUTO: next_profile = `UCPC_PROF_DCP_AUTO; // R15
      `UCPC_MODE_DCP_STD: next_profile = `UCPC_PROF_DCP_STD; // R15
      `UCPC_MODE_DCP_DIV: next_profile = `UCPC_PROF_DCP_DIV; // R15
      default: next_profile = `UCPC_PROF_OFF;
    endcase
  end
  wire is_cdp = (next_profile == `UCPC_PROF_CDP);
  wire is_dcp = (next_profile == `UCPC_PROF_DCP_AUTO) |
    (next_profile == `UCPC_PROF_DCP_STD) | (next_profile == `UCPC_PROF_DCP_DIV);

  // CDP handshake must precede current rise; latched until current drops
  reg hs_first;
  reg cur_d;
  always @(posedge clk_in) begin
    if (srst_in) begin
      hs_first <= 1'b0;
      cur_d <= 1'b0;
    end else begin
      cur_d <= cur_s;
      if (!en_s || !is_cdp)
        hs_first <= 1'b0;
      else if (cur_s && !cur_d)
        hs_first <= hs_s; // R2
      else if (!cur_s)
        hs_first <= 1'b0;
    end
  end

  // Attach detector and safety timer
  localparam ST_IDLE = 2'b00;
  localparam ST_PULSE = 2'b01;
  localparam ST_TIMING = 2'b10;
  localparam ST_EXPIRED = 2'b11;
  reg [1:0] state;
  reg [1:0] next_state;
  // 25 s at the core clock needs more than 32 bits
  reg [47:0] pulse_cnt;
  reg [47:0] safe_cnt;
  reg att_d;
  wire det_on = aen_s & ~en_s; // R7 R10
  wire attach_evt = det_on & att_s & ~att_d;
  wire pulse_done = (pulse_cnt == ATTACH_CYC - 48'h000000000001);
  wire safe_done = (safe_cnt == SAFETY_CYC - 48'h000000000001);
  wire timer_allowed = deep_sleep & on_battery; // R4

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (attach_evt)
          next_state = ST_PULSE; // R5
      end
      ST_PULSE: begin
        if (!aen_s)
          next_state = ST_IDLE; // R6
        else if (pulse_done)
          next_state = timer_allowed ? ST_TIMING : ST_IDLE;
      end
      ST_TIMING: begin
        if (!aen_s || !timer_allowed)
          next_state = ST_IDLE; // R6
        else if (safe_done)
          next_state = ST_EXPIRED; // R4
      end
      ST_EXPIRED: begin
        if (!aen_s || !timer_allowed)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      pulse_cnt <= 48'h000000000000;
      safe_cnt <= 48'h000000000000;
      att_d <= 1'b0;
    end else begin
      state <= next_state;
      att_d <= att_s;
      if (state == ST_PULSE && next_state == ST_PULSE)
        pulse_cnt <= pulse_cnt + 48'h000000000001; // R16 R8
      else
        pulse_cnt <= 48'h000000000000;
      if (state == ST_TIMING && next_state == ST_TIMING)
        safe_cnt <= safe_cnt + 48'h000000000001; // R16
      else
        safe_cnt <= 48'h000000000000;
    end
  end

  wire expired = (state == ST_EXPIRED);
  wire attach_pulse = (state == ST_PULSE); // R8
  wire charging = en_s & cur_s & ~expired & (is_dcp | (is_cdp & hs_first)); // R1 R2 R3
  reg indicate;

  // Outputs from flip-flops
  always @(posedge clk_in) begin
    if (srst_in) begin
      power_switch_on_out <= 1'b0;
      data_switch_on_out <= 1'b0;
      profile_out <= `UCPC_PROF_OFF;
      attach_detector_on_out <= 1'b0;
      indicate <= 1'b0;
    end else begin
      power_switch_on_out <= en_s & ~expired; // R9 R4
      data_switch_on_out <= en_s; // R9
      profile_out <= en_s ? next_profile : `UCPC_PROF_OFF; // R9 R13
      attach_detector_on_out <= det_on; // R7
      indicate <= charging | attach_pulse; // R3
    end
  end

  wire fault_level;
  ucpc_deglitch #(
    .W(16),
    .HOLD(`UCPC_DEGLITCH_CYC)
  ) u_fault (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .raw_in(fault_raw),
    .level_out(fault_level)
  );

  // Open drain: drive low only when asserted
  assign charge_attach_out = 1'b0;
  assign charge_attach_oe_out = indicate; // R12
  assign fault_out = 1'b0;
  assign fault_oe_out = fault_level; // R11

  // Interrupt events
  reg ind_d;
  reg flt_d;
  reg exp_d;
  always @(posedge clk_in) begin
    if (srst_in) begin
      ind_d <= 1'b0;
      flt_d <= 1'b0;
      exp_d <= 1'b0;
    end else begin
      ind_d <= charging;
      flt_d <= fault_level;
      exp_d <= expired;
    end
  end
  wire [`UCPC_IRQ_W-1:0] events = {charging & ~ind_d, fault_level & ~flt_d,
    expired & ~exp_d, attach_evt};
  assign irq_out = |(irq_stat & irq_mask);

  // Wishbone slave, one-cycle ack
  wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wb_wr = wb_req & wb_we_in & wb_sel_in[0];
  reg [31:0] next_rdata;
  always @* begin
    case (wb_adr_in)
      `UCPC_ADDR_CTRL: next_rdata = {30'h00000000, ctrl};
      `UCPC_ADDR_STATUS: next_rdata = {22'h000000, fault_level, indicate, expired,
        attach_pulse, state, next_profile, en_s};
      `UCPC_ADDR_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
      `UCPC_ADDR_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      ctrl <= 2'b00;
      irq_mask <= {`UCPC_IRQ_W{1'b0}};
      irq_stat <= {`UCPC_IRQ_W{1'b0}};
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in)
        wb_dat_out <= next_rdata;
      if (wb_wr && wb_adr_in == `UCPC_ADDR_CTRL)
        ctrl <= wb_dat_in[1:0];
      if (wb_wr && wb_adr_in == `UCPC_ADDR_IRQ_MASK)
        irq_mask <= wb_dat_in[`UCPC_IRQ_W-1:0];
      // Set wins over write-one-to-clear in the same cycle
      if (wb_wr && wb_adr_in == `UCPC_ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~wb_dat_in[`UCPC_IRQ_W-1:0]) | events;
      else
        irq_stat <= irq_stat | events;
    end
  end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
  n_fail = n_fail + 1; $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb;
  localparam logic [2:0] PT [0:7] = '{3'h0, 3'h3, 3'h1, 3'h0, 3'h4, 3'h5, 3'h1, 3'h2};
  reg clk_in = 1'b0, srst_in = 1'b1, enable_in = 1'b0, attach_enable_in = 1'b0;
  reg current_above_in = 1'b0, cdp_handshake_done_in = 1'b0, attach_sense_in = 1'b0;
  reg overcurrent_in = 1'b0, thermal_in = 1'b0, reverse_in = 1'b0;
  reg wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  reg [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'hF;
  reg [31:0] wb_dat_in = 32'h0, q = 32'h0;
  reg [2:0] md = 3'h0;
  wire mode_select_bit0_in = md[0], mode_select_bit1_in = md[1], mode_select_bit2_in = md[2];
  wire power_switch_on_out, data_switch_on_out, attach_detector_on_out, wb_ack_out, irq_out;
  wire charge_attach_out, charge_attach_oe_out, fault_out, fault_oe_out, ca_n, flt_n;
  wire [2:0] profile_out;
  wire [31:0] wb_dat_out;
  integer n_fail = 0, compares = 0, cyc = 0, m, c;
  // Short counts keep the pulse and the safety timer visible in a short run
  ucpc_top #(.ATTACH_CYC(48'h000000000032), .SAFETY_CYC(48'h000000000064)) dut (.*);
  ucpc_host_model host (.charge_attach_in(charge_attach_out),
    .charge_attach_oe_in(charge_attach_oe_out), .fault_in(fault_out),
    .fault_oe_in(fault_oe_out), .charge_attach_n_out(ca_n), .fault_n_out(flt_n));
  initial forever #2.5 clk_in = ~clk_in;
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task wb(input [3:0] a, input w, input [31:0] d);
    begin
      wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= w; wb_adr_in <= a; wb_dat_in <= d;
      @(posedge clk_in);
      while (wb_ack_out !== 1'b1) @(posedge clk_in);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0;
      tick(1);
    end
  endtask
  task t_modes;
    begin
      enable_in <= 1'b1;
      for (m = 1; m < 8; m = m + 1) begin
        md <= m[2:0];
        tick(6);
        if (m != 3) `CHK(profile_out, PT[m])
      end
      enable_in <= 1'b0;
      tick(6);
      `CHK({power_switch_on_out, data_switch_on_out, profile_out}, 5'h00)
      $display("modes done");
    end
  endtask
  task t_charge;
    begin
      md <= 3'h4; enable_in <= 1'b1; current_above_in <= 1'b1;
      tick(6);
      `CHK(ca_n, 1'b0)
      md <= 3'h7; current_above_in <= 1'b0;
      tick(6);
      `CHK(ca_n, 1'b1)
      current_above_in <= 1'b1;
      tick(6);
      `CHK(ca_n, 1'b1)
      current_above_in <= 1'b0; cdp_handshake_done_in <= 1'b1;
      tick(4);
      current_above_in <= 1'b1;
      tick(6);
      `CHK(ca_n, 1'b0)
      current_above_in <= 1'b0; cdp_handshake_done_in <= 1'b0; enable_in <= 1'b0;
      tick(6);
      $display("charge done");
    end
  endtask
  task t_attach;
    begin
      attach_enable_in <= 1'b1;
      wb(4'hC, 1'b1, 32'h3);
      tick(4);
      `CHK(attach_detector_on_out, 1'b1)
      attach_sense_in <= 1'b1;
      c = 0;
      while (ca_n !== 1'b0 && c < 10) begin tick(1); c = c + 1; end
      c = 0;
      while (ca_n === 1'b0 && c < 99) begin tick(1); c = c + 1; end
      `CHK(c >= 49 && c <= 51, 1'b1)
      `CHK(irq_out, 1'b1)
      wb(4'h8, 1'b1, 32'h1);
      `CHK(irq_out, 1'b0)
      attach_sense_in <= 1'b0;
      wb(4'h0, 1'b1, 32'h3);
      tick(200);
      wb(4'h4, 1'b0, 32'h0);
      `CHK(q[7], 1'b0)
      attach_sense_in <= 1'b1;
      tick(175);
      wb(4'h4, 1'b0, 32'h0);
      `CHK({q[7], ca_n, irq_out}, 3'h7)
      attach_enable_in <= 1'b0;
      tick(6);
      wb(4'h4, 1'b0, 32'h0);
      `CHK({q[7:4], attach_detector_on_out}, 5'h00)
      attach_sense_in <= 1'b0;
      $display("attach done");
    end
  endtask
  task t_fault;
    begin
      overcurrent_in <= 1'b1;
      tick(100);
      overcurrent_in <= 1'b0;
      tick(10);
      `CHK(flt_n, 1'b1)
      thermal_in <= 1'b1;
      tick(300);
      wb(4'h8, 1'b0, 32'h0);
      `CHK({flt_n, q[2]}, 2'h1)
      thermal_in <= 1'b0;
      $display("fault done");
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  initial begin
    tick(2);
    srst_in <= 1'b0;
    tick(1);
    t_modes;
    t_charge;
    t_attach;
    t_fault;
    finish_test;
  end
endmodule

// ==== sim/ucpc_host_model.sv ====
`timescale 1ns/1ps
module ucpc_host_model (
  // Open-drain drive from the block
  input wire charge_attach_in,
  input wire charge_attach_oe_in,
  input wire fault_in,
  input wire fault_oe_in,
  // Pin levels seen by the host
  output wire charge_attach_n_out,
  output wire fault_n_out
);
  // Released pins rise to the board pull-up
  assign charge_attach_n_out = charge_attach_oe_in ? charge_attach_in : 1'b1;
  assign fault_n_out = fault_oe_in ? fault_in : 1'b1;
endmodule

// ==== sim/ucpc_top_props.sv ====
`timescale 1ns/1ps
module ucpc_top_props (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Host pins
  input wire enable_in,
  input wire attach_enable_in,
  input wire mode_select_bit0_in,
  input wire mode_select_bit1_in,
  input wire mode_select_bit2_in,
  input wire overcurrent_in,
  input wire thermal_in,
  input wire reverse_in,
  // Block outputs
  input wire power_switch_on_out,
  input wire data_switch_on_out,
  input wire [2:0] profile_out,
  input wire attach_detector_on_out,
  input wire charge_attach_out,
  input wire charge_attach_oe_out,
  input wire fault_out,
  input wire fault_oe_out,
  input wire irq_out,
  // Bus
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_ack_out
);
  localparam logic [2:0] PT [0:7] = '{3'h0, 3'h3, 3'h1, 3'h0, 3'h4, 3'h5, 3'h1, 3'h2};
  wire [2:0] md = {mode_select_bit2_in, mode_select_bit1_in, mode_select_bit0_in};
  wire flt = overcurrent_in | thermal_in | reverse_in;
  // Run length of the raw fault, saturating so it cannot wrap
  reg [8:0] fc;
  always @(posedge clk_in) fc <= (srst_in || !flt) ? 9'h000 : fc + {8'h00, fc != 9'h1FF};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  chk_sw_off: assert property (!enable_in [*5] |->
    !power_switch_on_out && !data_switch_on_out && profile_out == 3'h0) else $error("on while off");
  chk_det_on: assert property ((attach_enable_in && !enable_in) [*5] |->
    attach_detector_on_out) else $error("detector not on");
  chk_det_off: assert property ((!attach_enable_in || enable_in) [*5] |->
    !attach_detector_on_out) else $error("detector not off");
  chk_prof_map: assert property ((enable_in && $stable(md) && PT[md] != 3'h0) [*5] |->
    profile_out == PT[md]) else $error("wrong profile");
  chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("late ack");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
  chk_od_low: assert property (!charge_attach_out && !fault_out) else $error("pin data high");
  chk_flt_hold: assert property ($rose(fault_oe_out) |-> $past(fc, 4) > 9'h0F0)
    else $error("fault not deglitched");
  cover property ($rose(charge_attach_oe_out));
  cover property ($rose(fault_oe_out));
  cover property ($rose(irq_out));
endmodule
bind ucpc_top ucpc_top_props chk (.*);
